// *** inc/tcf_pkg.sv ***
// Purpose: constants, carriers and field helpers of the coding path
// Assumes: symbols travel least significant bit first
// Notes:   Galois helpers serve elaboration and datapath alike
`default_nettype none
package tcf_pkg;
	localparam int SYM_W = 10;
	localparam int N_SYM = 528;
	localparam int K_SYM = 514;
	localparam int PAR = N_SYM - K_SYM;
	localparam int T_CORR = 7;
	localparam int BLK_W = 66;
	localparam int GRP = 4;
	localparam int XW = 257;
	localparam int BUF_W = XW + SYM_W - 1;
	localparam int GF_ORD = 1023;
	localparam logic [9:0] GF_RED = 10'h009;
	localparam logic [9:0] ALPHA = 10'h002;
	localparam logic [1:0] SH_DATA = 2'b10;
	localparam int PN_W = 58;
	localparam int PN_HI = 57;
	localparam int PN_LO = 38;
	localparam int PN_LEN = N_SYM * SYM_W;
	// Stage 57 high, then alternating downward
	localparam logic [57:0] PN_SEED = 58'h2AAAAAAAAAAAAAA;
	// Low type nibble, indexed by high type nibble
	localparam logic [15:0][3:0] TYPE_LO = 64'hF12C4A97865B3DE0;

	typedef logic [SYM_W-1:0] tcf_sym_t;
	typedef logic [PAR:0][SYM_W-1:0] tcf_poly_t;
	typedef struct packed {
		logic first;
		tcf_sym_t sym;
	} tcf_beat_t;
	typedef struct packed {
		logic uncorr;
		logic [BLK_W-1:0] blk;
	} tcf_rxblk_t;
	typedef struct packed {
		logic [PN_W-1:0] st;
		tcf_sym_t bits;
	} tcf_pnout_t;

	function automatic tcf_sym_t tcf_gmul(tcf_sym_t a, tcf_sym_t b);
		tcf_sym_t r;
		r = '0;
		for (int i = SYM_W - 1; i >= 0; i--) begin
			r = {r[SYM_W-2:0], 1'b0} ^ ({SYM_W{r[SYM_W-1]}} & GF_RED);
			r = r ^ ({SYM_W{b[i]}} & a);
		end
		return r;
	endfunction

	function automatic tcf_sym_t tcf_gpow(int e);
		tcf_sym_t r;
		int m;
		m = ((e % GF_ORD) + GF_ORD) % GF_ORD;
		r = 10'h001;
		for (int i = 0; i < m; i++) r = tcf_gmul(r, ALPHA);
		return r;
	endfunction

	// Inverse as a^(2^10-2)
	function automatic tcf_sym_t tcf_ginv(tcf_sym_t a);
		tcf_sym_t r;
		r = a;
		for (int i = 0; i < SYM_W - 2; i++) r = tcf_gmul(tcf_gmul(r, r), a);
		return tcf_gmul(r, r);
	endfunction

	function automatic tcf_poly_t tcf_powtab(int step);
		tcf_poly_t t;
		for (int i = 0; i <= PAR; i++) t[i] = tcf_gpow(step * i);
		return t;
	endfunction

	function automatic tcf_poly_t tcf_genpoly();
		tcf_poly_t g;
		tcf_sym_t a;
		g = '0;
		g[0] = 10'h001;
		for (int i = 0; i < PAR; i++) begin
			a = tcf_gpow(i);
			for (int k = i + 1; k >= 1; k--)
				g[k] = g[k-1] ^ tcf_gmul(g[k], a);
			g[0] = tcf_gmul(g[0], a);
		end
		return g;
	endfunction
endpackage
`default_nettype wire

// *** core/tcf_path.sv ***
// Purpose: 257-bit transcoding, RS(528,514) and noise scrambling path
// Assumes: far end paces receive symbols by rx_in_ready
// Notes:   receive decodes one code word at a time
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Word FIFO
// ------------------------------------------------------------
module tcf_fifo #(
	parameter int WIDTH = 66,
	parameter int DEPTH = 4
) (
	input  wire logic             clk,       // datapath clock
	input  wire logic             srst,      // sync reset
	input  wire logic [WIDTH-1:0] in_data,   // fill word
	input  wire logic             in_valid,  // fill offered
	output logic                  in_ready,  // room left
	output logic      [WIDTH-1:0] out_data,  // head word
	output logic                  out_valid, // head present
	input  wire logic             out_ready  // drain taken
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (1 << AW) != DEPTH)
		$error("tcf_fifo depth must be a power of two");
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 cnt;
		logic                        rdy;
	} tcf_fst_t;
	tcf_fst_t s, n;
	logic     push;
	logic     pop;

	assign push = in_valid && s.rdy;
	assign pop = (s.cnt != '0) && out_ready;
	assign in_ready = s.rdy;
	assign out_data = s.mem[s.rp];
	assign out_valid = s.cnt != '0;

	always_comb begin
		n = s;
		if (push) begin
			n.mem[s.wp] = in_data;
			n.wp = s.wp + 1'b1;
		end
		if (pop)
			n.rp = s.rp + 1'b1;
		n.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
		n.rdy = n.cnt < (AW+1)'(DEPTH);
	end

	always_ff @(posedge clk) begin
		if (srst)
			s <= '0;
		else
			s <= n;
	end
endmodule // tcf_fifo

// ------------------------------------------------------------
// Coding path
// ------------------------------------------------------------
module tcf_path #(
	parameter int FIFO_DEPTH = 4
) (
	input  wire logic                 clk,          // 40 MHz
	input  wire logic                 srst,         // sync reset
	input  wire logic [65:0]          tx_blk,       // 66-bit word in
	input  wire logic                 tx_blk_valid, // word offered
	output logic                      tx_blk_ready, // word taken
	output tcf_pkg::tcf_beat_t        tx_out,       // scrambled symbol
	output logic                      tx_out_valid, // symbol present
	input  wire tcf_pkg::tcf_beat_t   rx_in,        // received symbol
	input  wire logic                 rx_in_valid,  // symbol offered
	output logic                      rx_in_ready,  // symbol taken
	output tcf_pkg::tcf_rxblk_t       rx_out,       // rebuilt word
	output logic                      rx_out_valid  // word present
);
	import tcf_pkg::*;

	if (FIFO_DEPTH < 2)
		$error("tcf_path needs FIFO_DEPTH of two or more");

	localparam tcf_poly_t GEN = tcf_genpoly();
	localparam tcf_poly_t AUP = tcf_powtab(1);
	localparam tcf_poly_t AST = tcf_powtab(1 - N_SYM);

	typedef enum logic [2:0] {
		RX_COLLECT, RX_BM, RX_PREP, RX_CORR, RX_OUT
	} tcf_rxph_t;

	typedef struct packed {
		logic [GRP-1:0][BLK_W-1:0]   gblk;
		logic [2:0]                  gcnt;
		logic [BUF_W-1:0]            tbb;
		logic [8:0]                  tfill;
		logic [9:0]                  tsc;
		logic [PAR-1:0][SYM_W-1:0]   par;
		logic [PN_W-1:0]             tpn;
		tcf_beat_t                   tout;
		logic                        tvld;
		tcf_rxph_t                   ph;
		logic [N_SYM-1:0][SYM_W-1:0] cw;
		logic [9:0]                  ridx;
		logic [PAR-1:0][SYM_W-1:0]   syn;
		logic [PN_W-1:0]             rpn;
		tcf_poly_t                   lam;
		tcf_poly_t                   bpl;
		logic [4:0]                  len;
		logic [3:0]                  step;
		logic [T_CORR:0][SYM_W-1:0]  cl;
		logic [T_CORR-1:0][SYM_W-1:0] om;
		logic [9:0]                  roots;
		logic                        bad;
		logic [BUF_W-1:0]            obb;
		logic [8:0]                  ofill;
		logic [GRP-1:0][BLK_W-1:0]   ow;
		logic [2:0]                  ocnt;
		logic                        rrdy;
		tcf_rxblk_t                  rout;
		logic                        rvld;
	} tcf_st_t;

	tcf_st_t          s, n;
	logic [BLK_W-1:0] f_data;
	logic             f_valid;
	logic             f_ready;

	tcf_fifo #(.WIDTH(BLK_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk       (clk),
		.srst      (srst),
		.in_data   (tx_blk),
		.in_valid  (tx_blk_valid),
		.in_ready  (tx_blk_ready),
		.out_data  (f_data),
		.out_valid (f_valid),
		.out_ready (f_ready)
	);

	// x^58 + x^39 + 1 feedback
	function automatic tcf_pnout_t pn_run(logic [PN_W-1:0] st);
		tcf_pnout_t r;
		logic       fb;
		r.st = st;
		r.bits = '0;
		for (int k = 0; k < SYM_W; k++) begin
			fb = r.st[PN_HI] ^ r.st[PN_LO];
			r.bits[k] = fb;
			r.st = {r.st[PN_W-2:0], fb};
		end
		return r;
	endfunction

	function automatic logic [XW-1:0] tx_xcode(
		logic [GRP-1:0][BLK_W-1:0] c);
		logic [255:0] pay, comp, mask;
		logic [3:0]   h;
		int           l;
		l = 0;
		for (int j = GRP - 1; j >= 0; j--) begin
			h[j] = c[j][1];
			pay[64*j +: 64] = c[j][65:2];
			if (!h[j])
				l = j;
		end
		mask = (256'h1 << (64 * l)) - 256'h1;
		// Low type nibble dropped, rebuilt from high
		comp = (pay & mask) | ((pay >> 4) & ~mask);
		if (&h)
			return {pay, 1'b1};
		return {comp[251:0], h, 1'b0};
	endfunction

	function automatic logic [GRP-1:0][BLK_W-1:0] rx_xdecode(
		logic [XW-1:0] x);
		logic [GRP-1:0][BLK_W-1:0] c;
		logic [255:0] pay, comp, mask, hmask;
		logic [3:0]   h;
		int           l;
		l = 0;
		h = x[0] ? 4'hF : x[4:1];
		for (int j = GRP - 1; j >= 0; j--)
			if (!h[j])
				l = j;
		mask = (256'h1 << (64 * l)) - 256'h1;
		comp = {4'h0, x[XW-1:5]};
		// Restored nibble slot must not catch the word below
		hmask = (mask << 4) | 256'hF;
		pay = (comp & mask) | ((comp << 4) & ~hmask)
			| (256'(TYPE_LO[comp[64*l +: 4]]) << (64 * l));
		if (x[0])
			pay = x[XW-1:1];
		for (int j = 0; j < GRP; j++)
			c[j] = {pay[64*j +: 64], h[j], ~h[j]};
		return c;
	endfunction

	// drain FIFO until a group is full
	assign f_ready = s.gcnt < 3'(GRP);

	always_comb begin
		tcf_pnout_t pr;
		tcf_sym_t   d, fb, ev, od, ov;
		tcf_poly_t  xb;
		logic       emit;
		logic [9:0] idx;
		n = s;
		pr = '0;
		d = '0;
		fb = '0;
		ev = '0;
		od = '0;
		ov = '0;
		xb = '0;
		emit = 1'b0;
		idx = s.ridx;
		n.tvld = 1'b0;
		n.rvld = 1'b0;

		// ------------------------------------------------
		// Transmit
		// ------------------------------------------------
		if (f_valid && f_ready) begin
			n.gblk[s.gcnt[1:0]] = f_data;
			n.gcnt = s.gcnt + 3'd1;
		end
		if (s.tsc < 10'(K_SYM)) begin
			if (s.tfill >= 9'(SYM_W)) begin
				d = s.tbb[SYM_W-1:0];
				n.tbb = s.tbb >> SYM_W;
				n.tfill = s.tfill - 9'(SYM_W);
				emit = 1'b1;
			end else if (s.gcnt == 3'(GRP)) begin
				n.tbb = s.tbb
					| (BUF_W'(tx_xcode(s.gblk)) << s.tfill);
				n.tfill = s.tfill + 9'(XW);
				n.gcnt = '0;
			end
		end else begin
			d = s.par[PAR-1];
			n.par = {s.par[PAR-2:0], 10'h000};
			emit = 1'b1;
		end
		if (emit) begin
			pr = pn_run((s.tsc == '0) ? PN_SEED : s.tpn);
			n.tpn = pr.st;
			n.tout.sym = d ^ pr.bits;
			n.tout.first = s.tsc == '0;
			n.tvld = 1'b1;
			n.tsc = (s.tsc == 10'(N_SYM - 1)) ? '0 : s.tsc + 10'd1;
			if (s.tsc < 10'(K_SYM)) begin
				fb = d ^ s.par[PAR-1];
				for (int k = PAR - 1; k >= 1; k--)
					n.par[k] = s.par[k-1] ^ tcf_gmul(fb, GEN[k]);
				n.par[0] = tcf_gmul(fb, GEN[0]);
			end
		end

		// ------------------------------------------------
		// Receive
		// ------------------------------------------------
		// flag rides every output word
		if (s.ocnt != '0) begin
			n.rvld = 1'b1;
			n.rout.blk = s.ow[2'(3'(GRP) - s.ocnt)];
			n.rout.uncorr = s.bad;
			n.ocnt = s.ocnt - 3'd1;
		end
		case (s.ph)
			RX_COLLECT: begin
				// Unaligned symbols are taken and dropped until a first marker
				if (rx_in_valid && s.rrdy
					&& (rx_in.first || s.ridx != '0)) begin
					idx = rx_in.first ? '0 : s.ridx;
					pr = pn_run(rx_in.first ? PN_SEED : s.rpn);
					n.rpn = pr.st;
					d = rx_in.sym ^ pr.bits;
					n.cw[idx] = d;
					for (int i = 0; i < PAR; i++)
						n.syn[i] = d ^ (rx_in.first ? 10'h000
							: tcf_gmul(s.syn[i], AUP[i]));
					n.ridx = idx + 10'd1;
					if (idx == 10'(N_SYM - 1)) begin
						n.ph = RX_BM;
						n.lam = tcf_poly_t'(1);
						n.bpl = tcf_poly_t'(1);
						n.len = '0;
						n.step = '0;
					end
				end
			end
			RX_BM: begin
				// one error-locator step per cycle
				// Transmit may have left d set this cycle
				d = '0;
				for (int i = 0; i <= PAR; i++)
					if (i <= int'(s.step))
						d ^= tcf_gmul(s.lam[i],
							s.syn[int'(s.step) - i]);
				xb = {s.bpl[PAR-1:0], 10'h000};
				for (int i = 0; i <= PAR; i++)
					n.lam[i] = s.lam[i] ^ tcf_gmul(d, xb[i]);
				n.bpl = xb;
				if (d != '0 && {s.len, 1'b0} <= 6'(s.step)) begin
					fb = tcf_ginv(d);
					for (int i = 0; i <= PAR; i++)
						n.bpl[i] = tcf_gmul(s.lam[i], fb);
					n.len = 5'(s.step) + 5'd1 - s.len;
				end
				n.step = s.step + 4'd1;
				if (s.step == 4'(PAR - 1))
					n.ph = RX_PREP;
			end
			RX_PREP: begin
				n.bad = s.len > 5'(T_CORR);
				for (int i = 0; i <= T_CORR; i++)
					n.cl[i] = tcf_gmul(s.lam[i], AST[i]);
				for (int k = 0; k < T_CORR; k++) begin
					ov = '0;
					for (int i = 0; i <= k; i++)
						ov ^= tcf_gmul(s.syn[i], s.lam[k-i]);
					n.om[k] = tcf_gmul(ov, AST[k]);
				end
				n.roots = '0;
				n.ridx = '0;
				n.ph = n.bad ? RX_OUT : RX_CORR;
			end
			RX_CORR: begin
				for (int i = 0; i <= T_CORR; i++) begin
					ev ^= s.cl[i];
					if (i % 2 == 1)
						od ^= s.cl[i];
					n.cl[i] = tcf_gmul(s.cl[i], AUP[i]);
				end
				for (int k = 0; k < T_CORR; k++) begin
					ov ^= s.om[k];
					n.om[k] = tcf_gmul(s.om[k], AUP[k]);
				end
				if (ev == '0) begin
					n.roots = s.roots + 10'd1;
					if (od == '0)
						n.bad = 1'b1;
					else
						n.cw[s.ridx] = s.cw[s.ridx]
							^ tcf_gmul(ov, tcf_ginv(od));
				end
				n.ridx = s.ridx + 10'd1;
				if (s.ridx == 10'(N_SYM - 1)) begin
					if (n.roots != 10'(s.len))
						n.bad = 1'b1;
					n.ridx = '0;
					n.ph = RX_OUT;
				end
			end
			RX_OUT: begin
				if (s.ofill >= 9'(XW)) begin
					n.ow = rx_xdecode(s.obb[XW-1:0]);
					n.obb = s.obb >> XW;
					n.ofill = s.ofill - 9'(XW);
					n.ocnt = 3'(GRP);
				end else if (s.ridx < 10'(K_SYM)) begin
					n.obb = s.obb
						| (BUF_W'(s.cw[s.ridx]) << s.ofill);
					n.ofill = s.ofill + 9'(SYM_W);
					n.ridx = s.ridx + 10'd1;
				end else if (s.ocnt == '0) begin
					n.ridx = '0;
					n.ph = RX_COLLECT;
				end
			end
			default: n.ph = RX_COLLECT;
		endcase
		n.rrdy = n.ph == RX_COLLECT;
	end

	always_ff @(posedge clk) begin
		if (srst)
			s <= '0;
		else
			s <= n;
	end

	assign tx_out = s.tout;
	assign tx_out_valid = s.tvld;
	assign rx_in_ready = s.rrdy;
	assign rx_out = s.rout;
	assign rx_out_valid = s.rvld;
endmodule // tcf_path
`default_nettype wire

// *** verification/tcf_path_sva.sv ***
// Purpose: port-level assertions for the coding path
// Assumes: one clock, srst synchronous active high
// Notes:   counters track code word and word group position
`timescale 1ns/1ps
`default_nettype none
module tcf_path_sva
	import tcf_pkg::*;
#(
	parameter int FIFO_DEPTH = 4
) (
	input wire logic                clk,          // clock
	input wire logic                srst,         // reset
	input wire logic                tx_blk_ready, // fifo room
	input wire tcf_pkg::tcf_beat_t  tx_out,       // tx symbol
	input wire logic                tx_out_valid, // tx pulse
	input wire tcf_pkg::tcf_beat_t  rx_in,        // rx symbol
	input wire logic                rx_in_valid,  // rx offer
	input wire logic                rx_in_ready,  // rx accept
	input wire tcf_pkg::tcf_rxblk_t rx_out,       // rebuilt word
	input wire logic                rx_out_valid  // word pulse
);
	int   tx_cnt;
	int   rx_cnt;
	int   rcnt;
	logic uhold;
	logic take;

	// ----
	// Position counters
	// ----
	assign take = rx_in_valid & rx_in_ready & (rx_in.first | (rcnt != 0));
	always_ff @(posedge clk) begin
		if (srst) begin
			tx_cnt <= 0;
			rx_cnt <= 0;
			rcnt   <= 0;
			uhold  <= 1'b0;
		end else begin
			if (tx_out_valid)
				tx_cnt <= (tx_cnt == 527) ? 0 : tx_cnt + 1;
			if (rx_out_valid)
				rx_cnt <= (rx_cnt == 79) ? 0 : rx_cnt + 1;
			if (rx_out_valid && rx_cnt == 0)
				uhold <= rx_out.uncorr;
			if (take)
				rcnt <= rx_in.first ? 1 : ((rcnt == 527) ? 0 : rcnt + 1);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	// ----
	// Properties
	// ----
	property p_rst_quiet;
		disable iff (1'b0) srst |=> !tx_out_valid && !rx_out_valid;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet)
		else $error("output pulse during reset");
	property p_rdy_up;
		$fell(srst) |-> ##[0:2] (tx_blk_ready && rx_in_ready);
	endproperty
	a_rdy_up: assert property (p_rdy_up)
		else $error("readies not raised after reset");
	property p_first_pos;
		tx_out_valid |-> tx_out.first == (tx_cnt == 0);
	endproperty
	a_first_pos: assert property (p_first_pos)
		else $error("code word start marker misplaced");
	property p_par_burst;
		tx_out_valid && tx_cnt >= 514 && tx_cnt < 527 |=> tx_out_valid;
	endproperty
	a_par_burst: assert property (p_par_burst)
		else $error("gap inside parity symbols");
	property p_tx_hold;
		!tx_out_valid |-> $stable(tx_out);
	endproperty
	a_tx_hold: assert property (p_tx_hold)
		else $error("tx symbol moved without pulse");
	property p_grp4;
		rx_out_valid && (rx_cnt % 4) != 3 |=> rx_out_valid;
	endproperty
	a_grp4: assert property (p_grp4)
		else $error("rebuilt words not in groups of four");
	property p_uncorr_same;
		rx_out_valid && rx_cnt != 0 |-> rx_out.uncorr == uhold;
	endproperty
	a_uncorr_same: assert property (p_uncorr_same)
		else $error("flag changed inside code word");
	property p_rx_busy;
		take && rcnt == 527 && !rx_in.first |-> ##[1:2] !rx_in_ready [*8];
	endproperty
	a_rx_busy: assert property (p_rx_busy)
		else $error("receiver accepts during decode");
	property p_out_idle;
		$rose(rx_out_valid) |-> !rx_in_ready;
	endproperty
	a_out_idle: assert property (p_out_idle)
		else $error("output while collecting");

	c_uncorr: cover property (rx_out_valid && rx_out.uncorr);
	c_full: cover property ($fell(tx_blk_ready));
	c_rx_start: cover property (take && rx_in.first);
endmodule // tcf_path_sva
bind tcf_path tcf_path_sva #(.FIFO_DEPTH(FIFO_DEPTH)) u_sva (
	.clk(clk), .srst(srst), .tx_blk_ready(tx_blk_ready), .tx_out(tx_out),
	.tx_out_valid(tx_out_valid), .rx_in(rx_in), .rx_in_valid(rx_in_valid),
	.rx_in_ready(rx_in_ready), .rx_out(rx_out), .rx_out_valid(rx_out_valid));
`default_nettype wire

// *** verification/tcf_peer.sv ***
// Purpose: far-end link model looping tx symbols back to rx
// Assumes: ready is registered, so its value at fall is next sample
// Notes:   inverts leading symbols on command to inject errors
`timescale 1ns/1ps
`default_nettype none
module tcf_peer
	import tcf_pkg::*;
(
	input  wire logic         clk,              // clock
	input  wire logic         srst,             // reset
	input  wire tcf_pkg::tcf_beat_t tx_out,     // sent symbol
	input  wire logic         tx_out_valid,     // sent pulse
	input  wire logic [4:0]   n_err,            // symbols to invert
	input  wire logic         slow,             // insert gaps
	output tcf_pkg::tcf_beat_t rx_in = '0,      // link symbol
	output logic              rx_in_valid = 1'b0, // offered
	input  wire logic         rx_in_ready       // accepted
);
	tcf_beat_t q[$];
	tcf_beat_t b;
	logic took = 1'b0;
	logic gap = 1'b0;
	logic nv;
	int   idx = 0;

	always @(negedge clk) begin
		b = tx_out;
		if (tx_out_valid === 1'b1 && srst !== 1'b1) begin
			idx = b.first ? 0 : idx + 1;
			if (idx < n_err)
				b.sym = ~b.sym;
			q.push_back(b);
		end
		gap = slow & ~gap;
		nv = rx_in_valid && !took;
		if (srst === 1'b1) begin
			q.delete();
			nv = 1'b0;
		end else if (!nv && q.size() > 0 && !gap) begin
			rx_in <= q.pop_front();
			nv = 1'b1;
		end else if (!nv)
			rx_in <= ~rx_in;
		rx_in_valid <= nv;
		took <= nv & rx_in_ready;
	end
endmodule // tcf_peer
`default_nettype wire

// *** verification/transcode_rsfec_scramble_path_tb.sv ***
// Purpose: loopback bench for the coding path
// Assumes: inputs change at the falling edge
// Notes:   each scenario sends one full code word of 80 words
`timescale 1ns/1ps
`default_nettype none
module transcode_rsfec_scramble_path_tb;
	import tcf_pkg::*;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic [65:0] tx_blk = '0;
	logic        tx_blk_valid = 1'b0;
	logic        tx_blk_ready;
	logic        tx_out_valid;
	logic        rx_in_valid;
	logic        rx_in_ready;
	logic        rx_out_valid;
	tcf_beat_t   tx_out;
	tcf_beat_t   rx_in;
	tcf_rxblk_t  rx_out;
	logic [4:0]  n_err = '0;
	logic        slow = 1'b0;
	int          errors = 0;
	int          n_checks = 0;
	int          stalls = 0;
	tcf_rxblk_t  got_q[$];
	tcf_sym_t    sym0_q[$];

	always #12.5 clk = ~clk;

	tcf_path #(.FIFO_DEPTH(4)) dut_u (
		.clk(clk), .srst(srst), .tx_blk(tx_blk), .tx_blk_valid(tx_blk_valid),
		.tx_blk_ready(tx_blk_ready), .tx_out(tx_out),
		.tx_out_valid(tx_out_valid), .rx_in(rx_in), .rx_in_valid(rx_in_valid),
		.rx_in_ready(rx_in_ready), .rx_out(rx_out),
		.rx_out_valid(rx_out_valid));
	tcf_peer peer_u (
		.clk(clk), .srst(srst), .tx_out(tx_out), .tx_out_valid(tx_out_valid),
		.n_err(n_err), .slow(slow), .rx_in(rx_in), .rx_in_valid(rx_in_valid),
		.rx_in_ready(rx_in_ready));

	always @(negedge clk) begin
		if (rx_out_valid === 1'b1)
			got_q.push_back(rx_out);
		if (tx_out_valid === 1'b1 && tx_out.first === 1'b1)
			sym0_q.push_back(tx_out.sym);
	end

	// ----
	// Helpers
	// ----
	task automatic chk(input string nm, input logic [65:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	function automatic logic [65:0] mk(input int i, input bit ctl);
		logic [63:0] d;
		logic [3:0]  hi;
		d = {8{8'(i)}} ^ 64'h0123456789ABCDEF;
		hi = 4'(i);
		if (!ctl)
			return {d, SH_DATA};
		d[7:0] = {hi, TYPE_LO[hi]};
		return {d, 2'b01};
	endfunction

	task automatic send(input logic [65:0] w);
		logic rdy;
		tx_blk = w;
		tx_blk_valid = 1'b1;
		do begin
			rdy = tx_blk_ready;
			if (rdy !== 1'b1)
				stalls++;
			@(negedge clk);
		end while (rdy !== 1'b1);
	endtask

	task automatic run_cw(input int mode, input logic unc);
		logic [65:0] exp_q[$];
		logic [65:0] w;
		int t;
		got_q.delete();
		for (int i = 0; i < 80; i++) begin
			w = mk(i, mode == 2 || (mode == 1 && i % 3 == 0));
			exp_q.push_back(w);
			send(w);
		end
		tx_blk_valid = 1'b0;
		t = 0;
		while (got_q.size() < 80 && t < 6000) begin
			@(negedge clk);
			t++;
		end
		chk("rx word count", 66'(got_q.size()), 66'd80);
		foreach (got_q[k]) begin
			chk("uncorr", 66'(got_q[k].uncorr), 66'(unc));
			if (!unc)
				chk("rx word", got_q[k].blk, exp_q[k]);
		end
	endtask

	// ----
	// Scenarios
	// ----
	task automatic s_clean_data();
		logic [57:0] st;
		logic [65:0] w0;
		tcf_sym_t    e;
		run_cw(0, 1'b0);
		w0 = mk(0, 1'b0);
		st = PN_SEED;
		e = {w0[10:2], 1'b1};
		for (int i = 0; i < 10; i++) begin
			e[i] = e[i] ^ st[PN_HI] ^ st[PN_LO];
			st = {st[56:0], st[PN_HI] ^ st[PN_LO]};
		end
		chk("tx symbol 0", 66'(sym0_q[0]), 66'(e));
		chk("fifo refused", 66'(stalls > 0), 66'd1);
	endtask

	task automatic s_mixed_seven();
		n_err = 5'd7;
		slow = 1'b1;
		run_cw(1, 1'b0);
		slow = 1'b0;
	endtask

	task automatic s_ctrl_fixed();
		n_err = 5'd3;
		run_cw(2, 1'b0);
	endtask

	task automatic s_too_many();
		n_err = 5'd16;
		run_cw(0, 1'b1);
		n_err = 5'd0;
	endtask

	task automatic final_report();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge clk);
		errors++;
		final_report();
	end

	initial begin
		repeat (5) @(negedge clk);
		srst = 1'b0;
		repeat (2) @(negedge clk);
		s_clean_data();
		s_mixed_seven();
		s_ctrl_fixed();
		s_too_many();
		final_report();
	end
endmodule // transcode_rsfec_scramble_path_tb
`default_nettype wire
